/* src/tcs_top.sv */
// Six-channel timer count clock and clear select with Wishbone register access
//
// The placing of the registers and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "tcs_regs.svh"

module tcs_top #(
    parameter int CW = 16
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic EXT_COUNT_PIN_A,
    input wire logic EXT_COUNT_PIN_B,
    input wire logic EXT_COUNT_PIN_C,
    input wire logic EXT_COUNT_PIN_D,
    input wire logic [5:0] MATCH_A,
    input wire logic [5:0] MATCH_B,
    input wire logic [1:0] MATCH_C,
    input wire logic [1:0] MATCH_D,
    input wire logic PHASE_STEP,
    output logic [5:0] OVERFLOW
);
    import tcs_pkg::*;

    localparam int NCH = 6;

    tcs_ctrl_t ctrl [NCH];
    tcs_ctrl_t next_ctrl [NCH];
    logic [5:0] start, next_start, sync, next_sync;
    logic [4:0] mode, next_mode;
    logic ack, next_ack;
    logic [31:0] rdata, next_rdata;
    logic [`TCS_PRE_W-1:0] pre, next_pre;
    logic [3:0] pin_raw, s1, s2, s3, filt, next_filt;
    logic [CW-1:0] count [NCH];
    logic [5:0] ovf, clr_out;
    logic hit, wr;

    // ********************************
    // Decoding helpers
    // ********************************
    // Channel index of a per-channel address, or 7 when none
    function automatic logic [2:0] chan_of(input logic [7:0] adr, input logic [7:0] base);
        logic [7:0] d;
        d = adr - base;
        chan_of = (adr >= base && d[1:0] == 2'h0 && d[7:2] < 6'd6) ? d[4:2] : 3'h7;
    endfunction

    // Reserved bit 7 on channels without C/D
    function automatic tcs_ctrl_t ctrl_mask(input int ch);
        ctrl_mask = (ch == 0 || ch == 3) ? 8'hFF : `TCS_RSVD_MASK;
    endfunction

    // ********************************
    // Wishbone slave
    // ********************************
    assign hit = CYC_I & STB_I;
    // Write lands on the edge at which the master sees ack
    assign wr = hit & WE_I & ack & SEL_I[0];

    always_comb begin
        next_ack = hit & ~ack;
        next_rdata = rdata;
        if (hit && !ack) begin
            next_rdata = 32'h0;
            if (chan_of(ADR_I, `TCS_CTRL_BASE) != 3'h7) begin
                next_rdata[7:0] = ctrl[chan_of(ADR_I, `TCS_CTRL_BASE)];
            end else if (chan_of(ADR_I, `TCS_CNT_BASE) != 3'h7) begin
                next_rdata[CW-1:0] = count[chan_of(ADR_I, `TCS_CNT_BASE)];
            end else if (ADR_I == `TCS_START_OFS) begin
                next_rdata[5:0] = start;
            end else if (ADR_I == `TCS_SYNC_OFS) begin
                next_rdata[5:0] = sync;
            end else if (ADR_I == `TCS_MODE_OFS) begin
                next_rdata[4:0] = mode;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ack <= 1'b0;
            rdata <= 32'h0;
        end else begin
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    assign ACK_O = ack;
    assign DAT_O = rdata;

    // ********************************
    // Registers
    // ********************************
    always_comb begin
        next_ctrl = ctrl;
        next_start = start;
        next_sync = sync;
        next_mode = mode;
        if (wr) begin
            for (int i = 0; i < NCH; i++) begin
                if (chan_of(ADR_I, `TCS_CTRL_BASE) == 3'(i)) begin
                    next_ctrl[i] = DAT_I[7:0] & ctrl_mask(i);
                end
            end
            if (ADR_I == `TCS_START_OFS) begin
                next_start = DAT_I[5:0];
            end
            if (ADR_I == `TCS_SYNC_OFS) begin
                next_sync = DAT_I[5:0];
            end
            if (ADR_I == `TCS_MODE_OFS) begin
                next_mode = DAT_I[4:0];
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < NCH; i++) begin
                ctrl[i] <= `TCS_CTRL_RST;
            end
            start <= 6'h00;
            sync <= 6'h00;
            mode <= `TCS_MODE_RST;
        end else begin
            ctrl <= next_ctrl;
            start <= next_start;
            sync <= next_sync;
            mode <= next_mode;
        end
    end

    // ********************************
    // Prescaler and pin synchronisers
    // ********************************
    assign pin_raw = {EXT_COUNT_PIN_D, EXT_COUNT_PIN_C, EXT_COUNT_PIN_B, EXT_COUNT_PIN_A};

    assign next_pre = pre + 1'b1;

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            next_filt[k] = (s2[k] == s3[k]) ? s3[k] : filt[k];
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pre <= '0;
            s1 <= 4'h0;
            s2 <= 4'h0;
            s3 <= 4'h0;
            filt <= 4'h0;
        end else begin
            pre <= next_pre;
            s1 <= pin_raw;
            s2 <= s1;
            s3 <= s2;
            filt <= next_filt;
        end
    end

    // ********************************
    // Channels
    // ********************************
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        logic sync_in;
        assign sync_in = |(clr_out & ~(6'h01 << g));
        tcs_chan #(
            .CHAN(g),
            .CW(CW)
        ) u_chan (
            .clk(CLK),
            .rst_n(RST_N),
            .ctrl(ctrl[g]),
            .start(start[g]),
            .sync_en(sync[g]),
            .phase_mode((g == 1) ? mode[`TCS_MODE_PHASE1] : 1'b0),
            .phase_step(PHASE_STEP),
            .buf_c((g == 0) ? mode[`TCS_MODE_BUFC0] : mode[`TCS_MODE_BUFC3]),
            .buf_d((g == 0) ? mode[`TCS_MODE_BUFD0] : mode[`TCS_MODE_BUFD3]),
            .pre(pre),
            .ext(filt),
            // channel 2 overflow feeds channel 1
            .cascade(ovf[2]),
            .match_a(MATCH_A[g]),
            .match_b(MATCH_B[g]),
            .match_c((g == 0) ? MATCH_C[0] : (g == 3) ? MATCH_C[1] : 1'b0),
            .match_d((g == 0) ? MATCH_D[0] : (g == 3) ? MATCH_D[1] : 1'b0),
            .sync_in(sync_in),
            .count(count[g]),
            .ovf(ovf[g]),
            .clr_out(clr_out[g])
        );
    end

    assign OVERFLOW = ovf;

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_ctrl0_write;
        CYC_I && STB_I && WE_I && SEL_I[0] && ack && ADR_I == `TCS_CTRL_BASE;
    endsequence

    chk_ack_one_cycle: assert property (
        ack |=> !ack) else $error("ack held two cycles");
    chk_reserved_zero: assert property (
        !(ctrl[1][7] || ctrl[2][7] || ctrl[4][7] || ctrl[5][7]))
        else $error("reserved control bit set");
    chk_ctrl_write_lands: assert property (
        s_ctrl0_write |=> ctrl[0] == $past(DAT_I[7:0])) else $error("control write lost");
    chk_pin_filter: assert property (
        filt != $past(filt) |-> $past(s2) == $past(s3) && filt == $past(s3))
        else $error("pin level moved without agreement");

    // ********************************
    // Bus and cross-channel checks
    // ********************************
    sequence s_bus_take;
        CYC_I && STB_I && !ack;
    endsequence

    sequence s_bus_answer;
        ack ##1 !ack;
    endsequence

    sequence s_ctrl0_read;
        CYC_I && STB_I && !WE_I && !ack && ADR_I == `TCS_CTRL_BASE;
    endsequence

    sequence s_start_write;
        CYC_I && STB_I && WE_I && SEL_I[0] && ack && ADR_I == `TCS_START_OFS;
    endsequence

    // Lane 0 off: control 0, start, sync and mode may not move
    sequence s_unsel_write;
        CYC_I && STB_I && WE_I && ack && !SEL_I[0];
    endsequence

    // Channel 1 fed by channel 2 wrap, nothing to clear it
    sequence s_cascade_step;
        start[1] && !mode[`TCS_MODE_PHASE1] && ovf[2]
        && ctrl[1][`TCS_PSC_LSB+:3] == 3'h7
        && ctrl[1][`TCS_CLR_LSB+:3] == `TCS_CLR_NONE;
    endsequence

    chk_bus_answer: assert property (
        s_bus_take |=> s_bus_answer) else $error("bus request not answered in one cycle");
    chk_ctrl_read_data: assert property (
        s_ctrl0_read |=> DAT_O == {24'h0, $past(ctrl[0])}) else $error("control read wrong");
    chk_start_write: assert property (
        s_start_write |=> start == $past(DAT_I[5:0])) else $error("start write lost");
    chk_mode_write: assert property (
        CYC_I && STB_I && WE_I && SEL_I[0] && ack && ADR_I == `TCS_MODE_OFS
        |=> mode == $past(DAT_I[4:0])) else $error("mode write lost");
    chk_unsel_ignored: assert property (
        s_unsel_write |=> $stable(ctrl[0]) && $stable(start) && $stable(sync) && $stable(mode))
        else $error("write with lane 0 off changed a register");
    chk_stopped_hold: assert property (
        !start[0] |=> count[0] == '0 || $stable(count[0])) else $error("stopped counter moved");
    chk_cascade_step: assert property (
        s_cascade_step |=> count[1] == $past(count[1]) + 1'b1)
        else $error("cascade step missed");
endmodule // tcs_top
`default_nettype wire

/* inc/tcs_regs.svh */
// Register map, field positions and prescaler taps of the timer clock/clear select block
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH

// ********************************
// Register byte offsets
// ********************************
`define TCS_CTRL_BASE 8'h00
`define TCS_START_OFS 8'h18
`define TCS_SYNC_OFS 8'h1C
`define TCS_MODE_OFS 8'h20
`define TCS_CNT_BASE 8'h40

// ********************************
// Control register fields
// ********************************
`define TCS_CTRL_RST 8'h00
`define TCS_RSVD_MASK 8'h7F
`define TCS_CLR_LSB 5
`define TCS_EDGE_LSB 3
`define TCS_PSC_LSB 0
`define TCS_CLR_NONE 3'h0
`define TCS_CLR_A 3'h1
`define TCS_CLR_B 3'h2
`define TCS_CLR_C 3'h5
`define TCS_CLR_D 3'h6
`define TCS_EDGE_RISE 2'h0
`define TCS_EDGE_FALL 2'h1

// ********************************
// Mode register bits
// ********************************
`define TCS_MODE_PHASE1 0
`define TCS_MODE_BUFC0 1
`define TCS_MODE_BUFD0 2
`define TCS_MODE_BUFC3 3
`define TCS_MODE_BUFD3 4
`define TCS_MODE_RST 5'h00

// ********************************
// Prescaler taps (bit k-1 of a free counter gives clk/2^k)
// ********************************
`define TCS_PRE_W 8
`define TCS_DIV4_BIT 1
`define TCS_DIV16_BIT 3
`define TCS_DIV64_BIT 5
`define TCS_DIV256_BIT 7

`endif

/* inc/tcs_pkg.sv */
// Types shared by the timer clock/clear select block
`default_nettype none
package tcs_pkg;
    typedef logic [7:0] tcs_ctrl_t;
    typedef enum {TCS_SRC_NONE, TCS_SRC_DIRECT, TCS_SRC_LEVEL, TCS_SRC_PULSE} tcs_src_e;
endpackage
`default_nettype wire

/* src/tcs_chan.sv */
// One timer channel: count-source select, edge select, counter and clear select
`timescale 1ns/10ps
`default_nettype none
`include "tcs_regs.svh"

module tcs_chan #(
    parameter int CHAN = 0,
    parameter int CW = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire tcs_pkg::tcs_ctrl_t ctrl,
    input wire logic start,
    input wire logic sync_en,
    input wire logic phase_mode,
    input wire logic phase_step,
    input wire logic buf_c,
    input wire logic buf_d,
    input wire logic [`TCS_PRE_W-1:0] pre,
    input wire logic [3:0] ext,
    input wire logic cascade,
    input wire logic match_a,
    input wire logic match_b,
    input wire logic match_c,
    input wire logic match_d,
    input wire logic sync_in,
    output logic [CW-1:0] count,
    output logic ovf,
    output logic clr_out
);
    import tcs_pkg::*;

    logic [2:0] psc, clr_sel;
    logic [1:0] edge_sel;
    tcs_src_e kind;
    logic lvl, lvl_q, edge_hit, tick, own_clr, clr_now;
    logic [CW-1:0] next_count;
    logic next_ovf;

    assign psc = ctrl[`TCS_PSC_LSB+:3];
    assign edge_sel = ctrl[`TCS_EDGE_LSB+:2];
    assign clr_sel = ctrl[`TCS_CLR_LSB+:3];

    // ********************************
    // Count source
    // ********************************
    always_comb begin
        kind = TCS_SRC_LEVEL;
        lvl = 1'b0;
        unique case (psc)
            3'h0: kind = TCS_SRC_DIRECT;
            3'h1: lvl = pre[`TCS_DIV4_BIT];
            3'h2: lvl = pre[`TCS_DIV16_BIT];
            3'h3: lvl = pre[`TCS_DIV64_BIT];
            default: begin
                if (CHAN == 0) begin
                    lvl = ext[psc[1:0]];
                end else if (CHAN == 1) begin
                    if (psc == 3'h7) begin
                        kind = TCS_SRC_PULSE;
                    end else if (psc == 3'h6) begin
                        lvl = pre[`TCS_DIV256_BIT];
                    end else begin
                        lvl = ext[psc[1:0]];
                    end
                end else begin
                    // Upper codes of channels 2 to 5 are not built here
                    kind = TCS_SRC_NONE;
                end
            end
        endcase
    end

    // ********************************
    // Edge select and tick
    // ********************************
    always_comb begin
        if (edge_sel[1]) begin
            edge_hit = lvl ^ lvl_q;
        end else if (edge_sel == `TCS_EDGE_FALL) begin
            edge_hit = ~lvl & lvl_q;
        end else begin
            edge_hit = lvl & ~lvl_q;
        end
    end

    always_comb begin
        tick = 1'b0;
        if (phase_mode) begin
            tick = phase_step;
        end else begin
            unique case (kind)
                TCS_SRC_DIRECT: tick = 1'b1;
                TCS_SRC_PULSE: tick = cascade;
                TCS_SRC_LEVEL: tick = edge_hit;
                TCS_SRC_NONE: tick = 1'b0;
            endcase
        end
        tick = tick & start;
    end

    // ********************************
    // Clear select
    // ********************************
    always_comb begin
        own_clr = 1'b0;
        unique case (clr_sel)
            `TCS_CLR_A: own_clr = match_a;
            `TCS_CLR_B: own_clr = match_b;
            `TCS_CLR_C: own_clr = match_c & ~buf_c;
            `TCS_CLR_D: own_clr = match_d & ~buf_d;
            default: own_clr = 1'b0;
        endcase
        clr_now = own_clr | ((clr_sel[1:0] == 2'h3) & sync_en & sync_in);
        clr_out = own_clr & sync_en;
    end

    always_comb begin
        next_count = count;
        next_ovf = 1'b0;
        if (clr_now) begin
            next_count = '0;
        end else if (tick) begin
            next_count = count + 1'b1;
            next_ovf = &count;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            ovf <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            count <= next_count;
            ovf <= next_ovf;
            lvl_q <= lvl;
        end
    end

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_clear_wins_count: assert property (
        clr_now |=> count == '0) else $error("counter not cleared");
    chk_phase_hold_count: assert property (
        (phase_mode && !phase_step && !clr_now) |=> $stable(count))
        else $error("counter moved in phase mode without step");
    chk_buffer_no_clear: assert property (
        (clr_sel == `TCS_CLR_C && buf_c) |-> !own_clr) else $error("buffer reg cleared");
    chk_sync_clear_join: assert property (
        (clr_sel[1:0] == 2'h3 && sync_en && sync_in) |=> count == '0)
        else $error("sync clear missed");
    chk_sync_gate_out: assert property (
        !sync_en |-> !clr_out) else $error("unsynced channel drove sync clear");
    chk_div1_step: assert property (
        (start && !phase_mode && psc == 3'h0 && !clr_now) |=> count == $past(count) + 1'b1)
        else $error("undivided clock missed a count");
    chk_fall_only: assert property (
        (!phase_mode && kind == TCS_SRC_LEVEL && edge_sel == `TCS_EDGE_FALL
         && lvl && !lvl_q && !clr_now) |=> $stable(count))
        else $error("counted on rising edge in falling mode");
    chk_both_edges: assert property (
        (start && !phase_mode && kind == TCS_SRC_LEVEL && edge_sel[1]
         && lvl != lvl_q && !clr_now) |=> count == $past(count) + 1'b1)
        else $error("edge missed in both-edge mode");
endmodule // tcs_chan
`default_nettype wire

/* test/tcs_pin_model.sv */
// External count pin model: free-running square waves or static levels
`timescale 1ns/10ps
`default_nettype none

module tcs_pin_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [3:0] lvl,
    output logic [3:0] pin
);
    logic [4:0] ph;
    logic [4:0] next_ph;

    always_comb begin
        next_ph = ph + 5'h01;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph <= 5'h00;
        end else begin
            ph <= next_ph;
        end
    end

    // Pin k toggles every 2^(k+1) cycles, so each pin has its own rate
    assign pin = run ? ph[4:1] : lvl;
endmodule // tcs_pin_model
`default_nettype wire

/* test/timer_count_clock_clear_select_test.sv */
// Self-checking bench for the timer count clock and clear select block
`timescale 1ns/10ps
`default_nettype none
`include "tcs_regs.svh"
`define CHK(g, e) chk(32'(g), 32'(e))

module timer_count_clock_clear_select_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] sel = 4'hF;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat_w = 32'h0;
    logic [31:0] dat_r;
    logic ack;
    logic run = 1'b0;
    logic [3:0] lvl = 4'h0;
    logic [3:0] pin;
    logic [5:0] ma = 6'h00;
    logic [5:0] mb = 6'h00;
    logic [1:0] mc = 2'h0;
    logic [1:0] md = 2'h0;
    logic pstep = 1'b0;
    logic [5:0] ovf;
    int bad_count = 0;
    int check_count = 0;
    int nov = 0;
    logic [31:0] a, b, c, v;

    always #2 clk = ~clk;

    tcs_top #(.CW(10)) tcs_top_i (
        .CLK(clk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
        .EXT_COUNT_PIN_A(pin[0]), .EXT_COUNT_PIN_B(pin[1]),
        .EXT_COUNT_PIN_C(pin[2]), .EXT_COUNT_PIN_D(pin[3]),
        .MATCH_A(ma), .MATCH_B(mb), .MATCH_C(mc), .MATCH_D(md),
        .PHASE_STEP(pstep), .OVERFLOW(ovf)
    );

    tcs_pin_model tcs_pin_model_i (
        .clk(clk), .rst_n(rst_n), .run(run), .lvl(lvl), .pin(pin)
    );

    // Counted on the falling edge to stay clear of the launch edge
    always @(negedge clk) begin
        if (ovf[0] === 1'b1) begin
            nov++;
        end
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL t=%0t got %0h exp %0h", $time, g, e);
        end
    endtask

    // ********************************
    // Register bus master
    // ********************************
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        dat_w <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
        if (n >= 20) begin
            bad_count++;
            $display("FAIL t=%0t no bus answer", $time);
            print_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, ad, d, q);
    endtask

    task automatic rd(input logic [7:0] ad, output logic [31:0] q);
        bus(1'b0, ad, 32'h0, q);
    endtask

    function automatic logic [7:0] ca(input int ch);
        return 8'(`TCS_CTRL_BASE + 4 * ch);
    endfunction

    function automatic logic [7:0] cn(input int ch);
        return 8'(`TCS_CNT_BASE + 4 * ch);
    endfunction

    task automatic cfg(input int ch, input logic [7:0] ct, input logic [5:0] m);
        wr(`TCS_START_OFS, 32'h0);
        wr(ca(ch), {24'h0, ct});
        wr(`TCS_START_OFS, {26'h0, m});
    endtask

    // Reads take a fixed 3 cycles, so the sample spacing is w
    task automatic meas(input int ch, input int w, input int e);
        rd(cn(ch), a);
        repeat (w - 3) @(posedge clk);
        rd(cn(ch), b);
        `CHK((b - a) & 32'h3FF, e);
    endtask

    // Reference count per 512 cycles: pin k has period 2^(k+2)
    function automatic int rate(input int ch, input int cd, input int e);
        int r;
        if (cd < 4) begin
            r = 512 >> (2 * cd);
        end else if (ch == 1 && cd == 6) begin
            r = 2;
        end else begin
            r = 128 >> (cd - 4);
        end
        if (e >= 2 && cd != 0) begin
            r = r * 2;
        end
        return r;
    endfunction

    task automatic hit(input int s);
        case (s)
            0: ma[0] <= 1'b1;
            1: mb[0] <= 1'b1;
            2: mc[0] <= 1'b1;
            3: md[0] <= 1'b1;
            default: ma[3] <= 1'b1;
        endcase
        @(posedge clk);
        ma <= 6'h00;
        mb <= 6'h00;
        mc <= 2'h0;
        md <= 2'h0;
        @(posedge clk);
    endtask

    initial begin
        logic [7:0] d;
        logic h;
        void'($urandom(32'h17f1));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // ********************************
        // Register reset values and reserved bit
        // ********************************
        for (int ch = 0; ch < 6; ch++) begin
            rd(ca(ch), v);
            `CHK(v, `TCS_CTRL_RST);
            d = 8'($urandom());
            wr(ca(ch), {24'h0, d});
            rd(ca(ch), v);
            `CHK(v, (ch == 0 || ch == 3) ? d : d & `TCS_RSVD_MASK);
        end
        // Lane 0 off or counter target: write ignored
        wr(ca(0), 32'h11);
        sel <= 4'hE;
        wr(ca(0), 32'h5A);
        sel <= 4'hF;
        wr(cn(0), 32'h155);
        rd(ca(0), v);
        `CHK(v, 32'h11);
        rd(cn(0), v);
        `CHK(v, 0);
        wr(8'h30, $urandom());
        rd(8'h30, v);
        `CHK(v, 0);
        // ********************************
        // Count source and edge rates
        // ********************************
        run <= 1'b1;
        for (int ch = 0; ch < 2; ch++) begin
            for (int cd = 0; cd < 8; cd++) begin
                for (int e = 0; e < 3; e++) begin
                    if (ch == 1 && cd == 7) begin
                        continue;
                    end
                    cfg(ch, 8'((e << 3) | cd), 6'(1 << ch));
                    repeat (40) @(posedge clk);
                    meas(ch, 512, rate(ch, cd, e));
                end
            end
        end
        wr(ca(2), 32'h0);
        for (int e = 0; e < 3; e += 2) begin
            cfg(1, 8'((e << 3) | 7), 6'h06);
            repeat (10) @(posedge clk);
            meas(1, 2048, 2);
        end
        // Wrap pulses: 10-bit counter at full rate wraps every 1024 cycles
        cfg(0, 8'h00, 6'h01);
        c = 32'(nov);
        repeat (2048) @(posedge clk);
        `CHK(nov - int'(c), 2);
        // ********************************
        // Single pin edges
        // ********************************
        run <= 1'b0;
        for (int e = 0; e < 4; e++) begin
            cfg(0, 8'((e << 3) | 4), 6'h01);
            repeat (8) @(posedge clk);
            rd(cn(0), a);
            lvl <= 4'h1;
            repeat (8) @(posedge clk);
            rd(cn(0), b);
            lvl <= 4'h0;
            repeat (8) @(posedge clk);
            rd(cn(0), c);
            `CHK(b - a, e != 1);
            `CHK(c - b, e != 0);
        end
        // ********************************
        // Phase mode ignores the prescale field
        // ********************************
        wr(`TCS_MODE_OFS, 32'h1);
        cfg(1, 8'h00, 6'h02);
        meas(1, 64, 0);
        rd(cn(1), a);
        repeat (3) begin
            pstep <= 1'b1;
            @(posedge clk);
            pstep <= 1'b0;
            @(posedge clk);
        end
        rd(cn(1), b);
        `CHK(b - a, 3);
        // ********************************
        // Clear sources, buffers and sync clear
        // ********************************
        wr(ca(3), 32'h20);
        for (int k = 0; k < 3; k++) begin
            wr(`TCS_MODE_OFS, (k == 1) ? 32'h6 : 32'h0);
            wr(`TCS_SYNC_OFS, (k == 2) ? 32'h8 : 32'h9);
            for (int cl = 0; cl < 8; cl++) begin
                for (int s = 0; s < 5; s++) begin
                    cfg(0, 8'(cl << 5), 6'h01);
                    repeat (20) @(posedge clk);
                    wr(`TCS_START_OFS, 32'h0);
                    rd(cn(0), a);
                    hit(s);
                    rd(cn(0), b);
                    h = (cl == 1 && s == 0) || (cl == 2 && s == 1)
                        || (cl == 5 && s == 2 && k != 1) || (cl == 6 && s == 3 && k != 1)
                        || ((cl == 3 || cl == 7) && s == 4 && k != 2);
                    `CHK(b, h ? 32'h0 : a);
                end
            end
        end
        print_verdict();
    end
endmodule // timer_count_clock_clear_select_test
`default_nettype wire
